// >>> verilog/posc_defs.vh
// posc_defs.vh: register map, field positions and reset values of the power-on clear block
// assumes: included by posc_top.v only
// Function
// RULE1: flag true: event mask 255, others 0
// RULE2: flag false: save masks, restore at power-on
// RULE3: set argument 0 clears the flag
// RULE4: nonzero argument sets the flag true
// RULE5: out-of-range argument raises execution warning
// RULE6: query returns flag as integer, 1 true
// RULE7: flag itself kept in non-volatile storage
`ifndef POSC_DEFS_VH
`define POSC_DEFS_VH
// ----------------------------------------
// register word indexes
// ----------------------------------------
`define POSC_CMD_OFS     4'h0
`define POSC_QUERY_OFS   4'h1
`define POSC_DEV_OFS     4'h2
`define POSC_SRV_OFS     4'h3
`define POSC_STD_OFS     4'h4
`define POSC_STAT_OFS    4'h5
`define POSC_MASK_OFS    4'h6
`define POSC_PWR_OFS     4'h7
// ----------------------------------------
// fields and values
// ----------------------------------------
`define POSC_ARG_MAX     32'h0000FFFF
`define POSC_ARG_ZERO    32'h00000000
`define POSC_EV_WARN     0
`define POSC_EV_PON      1
`define POSC_EV_POFF     2
`define POSC_PWR_ON      0
`define POSC_PWR_OFF     1
`define POSC_DEV_CLR     8'hFF
`define POSC_ZERO_MASK   8'h00
`define POSC_NV_FLAG_RST 1'h0
`define POSC_MASK_RST    3'h0
`define POSC_STAT_RST    1'h0
`define POSC_ACK_RST     1'h0
`define POSC_RDATA_RST   32'h00000000
`endif

// >>> verilog/posc_top.v
// posc_top.v: power-on clear flag, three enable masks, their nv copies, avalon slave
// assumes: single clk_i domain; power events are one-cycle pulses decoded from bus writes to the power word
`default_nettype none
`include "posc_defs.vh"
module posc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    output wire [7:0]  device_event_enable_mask_o,
    output wire [7:0]  service_request_enable_mask_o,
    output wire [7:0]  standard_event_enable_mask_o,
    output wire        power_on_clear_flag_o,
    output wire        irq_o
);
// ----------------------------------------
// state
// ----------------------------------------

reg         flag_q;
reg         flag_d;
reg         nv_flag_q;
reg         nv_flag_d;
reg  [7:0]  dev_q;
reg  [7:0]  dev_d;
reg  [7:0]  srv_q;
reg  [7:0]  srv_d;
reg  [7:0]  std_q;
reg  [7:0]  std_d;
reg  [7:0]  nv_dev_q;
reg  [7:0]  nv_dev_d;
reg  [7:0]  nv_srv_q;
reg  [7:0]  nv_srv_d;
reg  [7:0]  nv_std_q;
reg  [7:0]  nv_std_d;
reg  [2:0]  mask_q;
reg  [2:0]  mask_d;
reg         ack_q;
reg         ack_d;
reg  [31:0] rdata_d;
wire [2:0]  stat_q;
wire        req;
wire        wr;
wire        rd;
wire        sel_cmd;
wire        sel_dev;
wire        sel_srv;
wire        sel_std;
wire        sel_stat;
wire        sel_mask;
wire        sel_pwr;
wire        arg_nz;
wire        pon;
wire        poff;
wire        warn;
wire [2:0]  ev;

// ----------------------------------------
// request decode
// ----------------------------------------

assign req               = (avs_read_i | avs_write_i) & ~ack_q;
assign wr                = avs_write_i & ~ack_q;
assign rd                = avs_read_i & ~ack_q;
assign sel_cmd           = (avs_address_i == `POSC_CMD_OFS);
assign sel_dev           = (avs_address_i == `POSC_DEV_OFS);
assign sel_srv           = (avs_address_i == `POSC_SRV_OFS);
assign sel_std           = (avs_address_i == `POSC_STD_OFS);
assign sel_stat          = (avs_address_i == `POSC_STAT_OFS);
assign sel_mask          = (avs_address_i == `POSC_MASK_OFS);
assign sel_pwr           = (avs_address_i == `POSC_PWR_OFS);
assign arg_nz            = (avs_writedata_i != `POSC_ARG_ZERO);
assign pon               = wr & sel_pwr & avs_writedata_i[`POSC_PWR_ON];
assign poff              = wr & sel_pwr & avs_writedata_i[`POSC_PWR_OFF];
assign warn              = wr & sel_cmd & (avs_writedata_i > `POSC_ARG_MAX); // RULE5
assign ev[`POSC_EV_WARN] = warn;
assign ev[`POSC_EV_PON]  = pon;
assign ev[`POSC_EV_POFF] = poff;

// ----------------------------------------
// outputs
// ----------------------------------------

assign avs_waitrequest_o             = req;
assign device_event_enable_mask_o    = dev_q;
assign service_request_enable_mask_o = srv_q;
assign standard_event_enable_mask_o  = std_q;
assign power_on_clear_flag_o         = flag_q;
assign irq_o                         = |(stat_q & mask_q);

// ----------------------------------------
// bus handshake: one wait cycle per access
// ----------------------------------------

always @* begin
    ack_d = req;
end

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ack_q <= `POSC_ACK_RST;
    end else begin
        ack_q <= ack_d;
    end
end

// ----------------------------------------
// power-on clear flag and its nv copy
// ----------------------------------------

always @* begin
    flag_d    = flag_q;
    nv_flag_d = nv_flag_q;
    if (wr && sel_cmd && !warn) begin
        flag_d    = arg_nz; // RULE3 RULE4
        nv_flag_d = arg_nz; // RULE7
    end
    if (pon) begin
        flag_d = nv_flag_q; // RULE7
    end
end

// ----------------------------------------
// enable masks
// ----------------------------------------

always @* begin
    dev_d = dev_q;
    srv_d = srv_q;
    std_d = std_q;
    if (wr && sel_dev) begin
        dev_d = avs_writedata_i[7:0];
    end
    if (wr && sel_srv) begin
        srv_d = avs_writedata_i[7:0];
    end
    if (wr && sel_std) begin
        std_d = avs_writedata_i[7:0];
    end
    if (pon) begin
        if (nv_flag_q) begin
            dev_d = `POSC_DEV_CLR; // RULE1
            srv_d = `POSC_ZERO_MASK;
            std_d = `POSC_ZERO_MASK;
        end else begin
            dev_d = nv_dev_q; // RULE2
            srv_d = nv_srv_q;
            std_d = nv_std_q;
        end
    end
end

// ----------------------------------------
// nv copies of the masks
// ----------------------------------------

always @* begin
    nv_dev_d = nv_dev_q;
    nv_srv_d = nv_srv_q;
    nv_std_d = nv_std_q;
    if (poff && !flag_q) begin
        nv_dev_d = dev_q; // RULE2
        nv_srv_d = srv_q;
        nv_std_d = std_q;
    end
end

// ----------------------------------------
// interrupt mask
// ----------------------------------------

always @* begin
    mask_d = mask_q;
    if (wr && sel_mask) begin
        mask_d = avs_writedata_i[2:0];
    end
end

// ----------------------------------------
// register bank
// ----------------------------------------

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        flag_q    <= `POSC_NV_FLAG_RST;
        nv_flag_q <= `POSC_NV_FLAG_RST;
        dev_q     <= `POSC_ZERO_MASK;
        srv_q     <= `POSC_ZERO_MASK;
        std_q     <= `POSC_ZERO_MASK;
        nv_dev_q  <= `POSC_ZERO_MASK;
        nv_srv_q  <= `POSC_ZERO_MASK;
        nv_std_q  <= `POSC_ZERO_MASK;
        mask_q    <= `POSC_MASK_RST;
    end else begin
        flag_q    <= flag_d;
        nv_flag_q <= nv_flag_d;
        dev_q     <= dev_d;
        srv_q     <= srv_d;
        std_q     <= std_d;
        nv_dev_q  <= nv_dev_d;
        nv_srv_q  <= nv_srv_d;
        nv_std_q  <= nv_std_d;
        mask_q    <= mask_d;
    end
end

// ----------------------------------------
// sticky status, write one to clear, set wins
// ----------------------------------------

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_stat
        reg sticky_q;
        reg sticky_d;
        assign stat_q[g] = sticky_q;
        always @* begin
            sticky_d = sticky_q;
            if (wr && sel_stat && avs_writedata_i[g]) begin
                sticky_d = 1'h0;
            end
            if (ev[g]) begin
                sticky_d = 1'h1;
            end
        end
        always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                sticky_q <= `POSC_STAT_RST;
            end else begin
                sticky_q <= sticky_d;
            end
        end
    end
endgenerate

// ----------------------------------------
// read data
// ----------------------------------------

always @* begin
    case (avs_address_i)
        `POSC_CMD_OFS:   rdata_d = {31'h0, flag_q};
        `POSC_QUERY_OFS: rdata_d = {31'h0, flag_q}; // RULE6
        `POSC_DEV_OFS:   rdata_d = {24'h0, dev_q};
        `POSC_SRV_OFS:   rdata_d = {24'h0, srv_q};
        `POSC_STD_OFS:   rdata_d = {24'h0, std_q};
        `POSC_STAT_OFS:  rdata_d = {29'h0, stat_q};
        `POSC_MASK_OFS:  rdata_d = {29'h0, mask_q};
        default:         rdata_d = `POSC_RDATA_RST;
    endcase
end

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        avs_readdata_o <= `POSC_RDATA_RST;
    end else if (rd) begin
        avs_readdata_o <= rdata_d;
    end
end

endmodule
`default_nettype wire

// >>> verif/posc_checker.sv
// posc_checker.sv: port assertions
// assumes: bound into posc_top
`default_nettype none
module posc_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        power_on_clear_flag_o,
    input wire logic [3:0]  avs_address_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic [7:0]  device_event_enable_mask_o,
    input wire logic [7:0]  service_request_enable_mask_o,
    input wire logic [7:0]  standard_event_enable_mask_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire        f = power_on_clear_flag_o;
    wire [31:0] d = avs_writedata_i;
    wire        c = avs_write_i & avs_waitrequest_o & avs_address_i == 4'h0;
    wire        p = avs_write_i & avs_waitrequest_o & avs_address_i == 4'h7;
    wire [23:0] m = {device_event_enable_mask_o, service_request_enable_mask_o, standard_event_enable_mask_o};
    reg  [23:0] sv_q;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sv_q <= 24'h000000;
        end else if (p && d[1] && !f) begin
            sv_q <= m;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence pon_s;
        p && d[0];
    endsequence
    mask_load_a: assert property (pon_s ##0 f |=> m == 24'hFF0000) else $error("mask load");
    mask_restore_a: assert property (pon_s ##0 !f |=> m == $past(sv_q)) else $error("restore");
    flag_clear_a: assert property (c && d == 32'h0 |=> !f) else $error("clear");
    flag_set_a: assert property (c && d != 32'h0 && d <= 32'h0000FFFF |=> f) else $error("set");
    range_keep_a: assert property (c && d > 32'h0000FFFF |=> $stable(f)) else $error("range");
    query_data_a: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 4'h1
        |=> avs_readdata_o == {31'h0, $past(f)}) else $error("query");
    flag_kept_a: assert property (pon_s |=> f == $past(f)) else $error("flag kept");
    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait cycle");
endmodule
bind posc_top posc_checker i_posc_checker (
    .clk_i                         (clk_i),
    .rst_i                         (rst_i),
    .avs_read_i                    (avs_read_i),
    .avs_write_i                   (avs_write_i),
    .avs_waitrequest_o             (avs_waitrequest_o),
    .power_on_clear_flag_o         (power_on_clear_flag_o),
    .avs_address_i                 (avs_address_i),
    .avs_writedata_i               (avs_writedata_i),
    .avs_readdata_o                (avs_readdata_o),
    .device_event_enable_mask_o    (device_event_enable_mask_o),
    .service_request_enable_mask_o (service_request_enable_mask_o),
    .standard_event_enable_mask_o  (standard_event_enable_mask_o)
);
`default_nettype wire

// >>> verif/posc_host.sv
// posc_host.sv: avalon master for the remote controller
// assumes: slave answers by waitrequest low
`default_nettype none
module posc_host (
    input  wire logic        clk_i,
    input  wire logic        wt_i,
    input  wire logic [31:0] rdata_i,
    output logic      [3:0]  ad_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [31:0] wd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ad_o, rd_o, wr_o, wd_o} = '0;
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        {ad_o, wd_o, wr_o, rd_o} <= {a, d, w, !w};
        @(posedge clk_i iff !wt_i);
        q = rdata_i;
        {wr_o, rd_o} <= 2'b00;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> verif/posc_top_tb.sv
// posc_top_tb.sv: command, query, power cycle and warning tests
// assumes: posc_host masters the slave port
`default_nettype none
module posc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic        power_on_clear_flag_o, irq_o;
    logic [3:0]  avs_address_i;
    logic [7:0]  device_event_enable_mask_o, service_request_enable_mask_o, standard_event_enable_mask_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    int          fails = 0, num_checks = 0, cyc = 0;
    wire  [31:0] ms = {8'h00, device_event_enable_mask_o, service_request_enable_mask_o, standard_event_enable_mask_o};
    posc_top i_posc_top (
        .clk_i                         (clk_i),
        .rst_i                         (rst_i),
        .avs_address_i                 (avs_address_i),
        .avs_read_i                    (avs_read_i),
        .avs_write_i                   (avs_write_i),
        .avs_writedata_i               (avs_writedata_i),
        .avs_readdata_o                (avs_readdata_o),
        .avs_waitrequest_o             (avs_waitrequest_o),
        .device_event_enable_mask_o    (device_event_enable_mask_o),
        .service_request_enable_mask_o (service_request_enable_mask_o),
        .standard_event_enable_mask_o  (standard_event_enable_mask_o),
        .power_on_clear_flag_o         (power_on_clear_flag_o),
        .irq_o                         (irq_o)
    );
    posc_host i_posc_host (.clk_i(clk_i), .wt_i(avs_waitrequest_o), .rdata_i(avs_readdata_o), .ad_o(avs_address_i),
        .rd_o(avs_read_i), .wr_o(avs_write_i), .wd_o(avs_writedata_i));
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc == 3000) begin fails++; finish_test(); end
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin fails++; $display("[ERR] %s exp %h seen %h", n, e, s); end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic w(input logic [3:0] a, input logic [31:0] d);
        i_posc_host.xfer(1'b1, a, d, q);
    endtask
    task automatic r(input string n, input logic [3:0] a, input logic [31:0] e);
        i_posc_host.xfer(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask
    task automatic setm(input logic [23:0] v);
        w(4'h2, {24'h0, v[23:16]});
        w(4'h3, {24'h0, v[15:8]});
        w(4'h4, {24'h0, v[7:0]});
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset masks", ms, 32'h0);
        chk("reset flag", power_on_clear_flag_o, 32'h0);
        r("query", 4'h1, 32'h0);
        r("unmapped", 4'h8, 32'h0);
        setm(24'h123456);
        w(4'h0, 32'h1);
        r("query", 4'h1, 32'h1);
        r("cmd", 4'h0, 32'h1);
        w(4'h7, 32'h2);
        w(4'h7, 32'h1);
        chk("masks", ms, 32'hFF0000);
        chk("flag", power_on_clear_flag_o, 32'h1);
        w(4'h0, 32'h0);
        r("query", 4'h1, 32'h0);
        setm(24'h123456);
        w(4'h7, 32'h2);
        setm(24'h000000);
        w(4'h7, 32'h1);
        chk("masks", ms, 32'h123456);
        chk("flag", power_on_clear_flag_o, 32'h0);
        r("dev mask", 4'h2, 32'h12);
        r("srv mask", 4'h3, 32'h34);
        r("std mask", 4'h4, 32'h56);
        w(4'h6, 32'h1);
        r("irq mask", 4'h6, 32'h1);
        w(4'h0, 32'h10000);
        chk("flag", power_on_clear_flag_o, 32'h0);
        chk("irq", irq_o, 32'h1);
        w(4'h6, 32'h0);
        chk("irq masked", irq_o, 32'h0);
        r("status", 4'h5, 32'h7);
        w(4'h5, 32'h3);
        r("status cleared", 4'h5, 32'h4);
        w(4'h6, 32'h1);
        chk("irq cleared", irq_o, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
